// ==== include/csft_pkg.sv ====
// constants and types shared by the codec serial frame timing block
package csft_pkg;
    localparam int WORD_SLOT = 20;
    localparam int WORD_BITS = 16;
    localparam int BYTE_SLOT = 12;
    localparam int BYTE_BITS = 8;
    localparam int SAMPLE_W  = 16;
    localparam int DIR_RX    = 0;
    localparam int DIR_TX    = 1;
    localparam int DEF_ADC_PERIOD = 40;
    localparam int DEF_DAC_PERIOD = 40;
    localparam logic [2:0] RATIO_X1 = 3'h1;
    localparam logic [2:0] RATIO_X2 = 3'h2;
    localparam logic [2:0] RATIO_X4 = 3'h4;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 16'h0000;

    typedef struct packed {
        logic frame_sync_n;
        logic end_marker_n;
    } csft_frame_t;
endpackage

// ==== verilog/csft_frame_timing.sv ====
// codec serial port framing, end markers, sample crossing and gain decode
//
// Operation
// [RULE1] receive frame sync falls once per A/D conversion period; in byte mode the code drops it twice per period, once per byte
// [RULE2] transmit frame sync falls once per D/A conversion period; in byte mode the code drops it twice per period, once per byte
// [RULE3] word format: both end markers go low after sixteen bits shifted
// [RULE4] word format: word cycle is twenty shift clocks, sixteen data plus four setup
// [RULE5] byte mode: end marker high for first byte, low for second byte
// [RULE6] byte mode: byte cycle is twelve shift clocks, eight data plus four setup
// [RULE7] gain bits equal give ratio one, low alone two, high alone four
// [RULE8] frame sync low one shift clock, first data bit on next clock
`timescale 1ns/1ps
module csft_frame_timing #(
    parameter int ADC_PERIOD = csft_pkg::DEF_ADC_PERIOD, // shift clocks per A/D sample
    parameter int DAC_PERIOD = csft_pkg::DEF_DAC_PERIOD  // shift clocks per D/A sample
) (
    input  wire logic                          clk,                   // system clock
    input  wire logic                          reset_n,               // sync reset, low
    input  wire logic                          shift_clk,             // link shift clock
    input  wire logic                          byte_mode,             // 1 byte, 0 word
    input  wire logic                          gain_select_low_bit,   // gain control low
    input  wire logic                          gain_select_high_bit,  // gain control high
    output logic [2:0]                         feedback_ratio,        // 1, 2 or 4
    input  wire logic [csft_pkg::SAMPLE_W-1:0] adc_word,              // next A/D sample
    input  wire logic                          adc_valid,             // sample offered
    output logic                               adc_ready,             // sample accepted
    output logic [csft_pkg::SAMPLE_W-1:0]      dac_word,              // received D/A word
    output logic                               dac_valid,             // one-cycle pulse
    input  wire logic                          transmit_data_in,      // serial in from host
    output logic                               receive_data_out,      // serial out to host
    output logic                               receive_frame_sync_n,  // A/D frame sync
    output logic                               transmit_frame_sync_n, // D/A frame sync
    output logic                               receive_end_marker_n,  // A/D end marker
    output logic                               transmit_end_marker_n  // D/A end marker
);
    import csft_pkg::*;

    localparam int A_WEND = WORD_BITS + 1;
    localparam int A_RXP  = ADC_PERIOD;
    localparam int A_TXP  = DAC_PERIOD;

    logic [1:0]          link_rst_reg;
    logic                link_rst_n;
    logic [1:0]          mode_sync_reg;
    logic [1:0]          req_sync_reg;
    logic [1:0]          ack_sync_reg;
    logic [1:0]          dac_sync_reg;
    logic                req_tog_reg;
    logic                ack_tog_reg;
    logic                dac_tog_reg;
    logic                dac_seen_reg;
    logic [SAMPLE_W-1:0] adc_hold_reg;
    logic [SAMPLE_W-1:0] adc_stage_reg;
    logic [SAMPLE_W-1:0] rx_shift_reg;
    logic [SAMPLE_W-1:0] tx_cap_reg;
    logic [SAMPLE_W-1:0] dac_hold_reg;
    logic [SAMPLE_W-1:0] dac_word_reg;
    logic                dac_valid_reg;
    logic                adc_ready_reg;
    logic                rx_out_reg;
    logic                tx_take_reg;
    logic                tx_last_reg;
    logic [2:0]          ratio_reg;

    // reset and mode carried into the link domain
    always_ff @(posedge shift_clk) begin
        link_rst_reg  <= {link_rst_reg[0], reset_n};
        mode_sync_reg <= {mode_sync_reg[0], byte_mode};
    end
    assign link_rst_n = link_rst_reg[1];

    // frame engine per direction
    for (genvar d = 0; d < 2; d++) begin : g_dir
        localparam int PER = (d == DIR_RX) ? ADC_PERIOD : DAC_PERIOD;
        localparam int CW  = $clog2(PER);
        logic [CW-1:0] cnt_reg;
        logic          mode_reg;
        csft_frame_t   frame_reg;
        csft_frame_t   frame_next;
        logic [CW-1:0] off;
        logic [CW-1:0] nbits;
        logic          second;
        logic          in_slot;
        logic          data_clk;
        logic          last_bit;

        always_comb begin
            second  = mode_reg && (cnt_reg >= CW'(BYTE_SLOT)) && (cnt_reg < CW'(2 * BYTE_SLOT));
            off     = second ? CW'(cnt_reg - CW'(BYTE_SLOT)) : cnt_reg;
            in_slot = mode_reg ? (cnt_reg < CW'(2 * BYTE_SLOT)) // see [RULE6]
                               : (cnt_reg < CW'(WORD_SLOT));    // see [RULE4]
            nbits   = mode_reg ? CW'(BYTE_BITS) : CW'(WORD_BITS);
            data_clk = in_slot && (off >= CW'(1)) && (off <= nbits); // see [RULE8]
            last_bit = data_clk && (off == nbits) && (second || !mode_reg);
            frame_next.frame_sync_n = !(in_slot && (off == '0)); // see [RULE8]
            if (mode_reg) begin
                frame_next.end_marker_n = !second;                  // see [RULE5]
            end else begin
                frame_next.end_marker_n = !(in_slot && (off > nbits)); // see [RULE3]
            end
        end

        always_ff @(posedge shift_clk) begin
            if (!link_rst_n) begin
                cnt_reg   <= '0;
                mode_reg  <= 1'b0;
                frame_reg <= '1;
            end else begin
                // period wrap spaces frame starts, see [RULE1] [RULE2]
                cnt_reg   <= (cnt_reg == CW'(PER - 1)) ? '0 : CW'(cnt_reg + 1'b1);
                if (cnt_reg == CW'(PER - 1)) begin
                    mode_reg <= mode_sync_reg[1];
                end
                frame_reg <= frame_next;
            end
        end
    end

    assign receive_frame_sync_n  = g_dir[DIR_RX].frame_reg.frame_sync_n;
    assign receive_end_marker_n  = g_dir[DIR_RX].frame_reg.end_marker_n;
    assign transmit_frame_sync_n = g_dir[DIR_TX].frame_reg.frame_sync_n;
    assign transmit_end_marker_n = g_dir[DIR_TX].frame_reg.end_marker_n;
    assign receive_data_out      = rx_out_reg;

    // A/D sample offer, held until the link domain acknowledges it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            adc_hold_reg  <= SAMPLE_RST;
            req_tog_reg   <= 1'b0;
            adc_ready_reg <= 1'b1;
            ack_sync_reg  <= '0;
        end else begin
            ack_sync_reg <= {ack_sync_reg[0], ack_tog_reg};
            if (adc_valid && adc_ready_reg) begin
                adc_hold_reg  <= adc_word;
                req_tog_reg   <= ~req_tog_reg;
                adc_ready_reg <= 1'b0;
            end else if (!adc_ready_reg && (ack_sync_reg[1] == req_tog_reg)) begin
                adc_ready_reg <= 1'b1;
            end
        end
    end
    assign adc_ready = adc_ready_reg;

    // link side of the A/D handshake and serial shift out
    always_ff @(posedge shift_clk) begin
        if (!link_rst_n) begin
            req_sync_reg  <= '0;
            ack_tog_reg   <= 1'b0;
            adc_stage_reg <= SAMPLE_RST;
            rx_shift_reg  <= SAMPLE_RST;
            rx_out_reg    <= 1'b0;
        end else begin
            req_sync_reg <= {req_sync_reg[0], req_tog_reg};
            if (req_sync_reg[1] != ack_tog_reg) begin
                adc_stage_reg <= adc_hold_reg;
                ack_tog_reg   <= req_sync_reg[1];
            end
            if (g_dir[DIR_RX].cnt_reg == '0) begin
                rx_shift_reg <= adc_stage_reg;
            end else if (g_dir[DIR_RX].data_clk) begin
                rx_out_reg   <= rx_shift_reg[SAMPLE_W-1]; // see [RULE8]
                rx_shift_reg <= {rx_shift_reg[SAMPLE_W-2:0], 1'b0};
            end
        end
    end

    // serial capture, one clock behind the slot so the host can answer
    always_ff @(posedge shift_clk) begin
        if (!link_rst_n) begin
            tx_take_reg  <= 1'b0;
            tx_last_reg  <= 1'b0;
            tx_cap_reg   <= SAMPLE_RST;
            dac_hold_reg <= SAMPLE_RST;
            dac_tog_reg  <= 1'b0;
        end else begin
            tx_take_reg <= g_dir[DIR_TX].data_clk;
            tx_last_reg <= g_dir[DIR_TX].last_bit;
            if (tx_take_reg) begin
                tx_cap_reg <= {tx_cap_reg[SAMPLE_W-2:0], transmit_data_in};
            end
            if (tx_last_reg) begin
                dac_hold_reg <= {tx_cap_reg[SAMPLE_W-2:0], transmit_data_in};
                dac_tog_reg  <= ~dac_tog_reg;
            end
        end
    end

    // D/A word handed to the system domain
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dac_sync_reg  <= '0;
            dac_seen_reg  <= 1'b0;
            dac_word_reg  <= SAMPLE_RST;
            dac_valid_reg <= 1'b0;
        end else begin
            dac_sync_reg  <= {dac_sync_reg[0], dac_tog_reg};
            dac_seen_reg  <= dac_sync_reg[1];
            dac_valid_reg <= (dac_sync_reg[1] != dac_seen_reg);
            if (dac_sync_reg[1] != dac_seen_reg) begin
                dac_word_reg <= dac_hold_reg;
            end
        end
    end
    assign dac_word  = dac_word_reg;
    assign dac_valid = dac_valid_reg;

    // input gain decode
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ratio_reg <= RATIO_X1;
        end else if (gain_select_low_bit == gain_select_high_bit) begin
            ratio_reg <= RATIO_X1; // see [RULE7]
        end else begin
            ratio_reg <= gain_select_low_bit ? RATIO_X2 : RATIO_X4; // see [RULE7]
        end
    end
    assign feedback_ratio = ratio_reg;

    // frame start: sync falls while the end marker is high
    sequence rx_start_s;
        $fell(receive_frame_sync_n) && receive_end_marker_n;
    endsequence
    sequence tx_start_s;
        $fell(transmit_frame_sync_n) && transmit_end_marker_n;
    endsequence
    sequence tx_word_end_s;
        ##A_WEND !transmit_end_marker_n [*3] ##1 transmit_end_marker_n;
    endsequence

    rx_period_a: assert property (@(posedge shift_clk) disable iff (!link_rst_n) // see [RULE1]
        rx_start_s |-> ##A_RXP rx_start_s)
        else $error("receive frame start spacing wrong");
    tx_period_a: assert property (@(posedge shift_clk) disable iff (!link_rst_n) // see [RULE2]
        tx_start_s |-> ##A_TXP tx_start_s)
        else $error("transmit frame start spacing wrong");
    // outputs show the counter one clock late, so the marker rises 20 clocks after the sync
    word_marker_a: assert property (@(posedge shift_clk) disable iff (!link_rst_n) // see [RULE3]
        (tx_start_s ##0 !g_dir[DIR_TX].mode_reg) |-> tx_word_end_s)
        else $error("word end marker timing wrong");
    word_cycle_a: assert property (@(posedge shift_clk) disable iff (!link_rst_n) // see [RULE4]
        (rx_start_s ##0 !g_dir[DIR_RX].mode_reg) |->
        ##1 receive_frame_sync_n [*8] ##12 $rose(receive_end_marker_n))
        else $error("word cycle length wrong");
    byte_marker_a: assert property (@(posedge shift_clk) disable iff (!link_rst_n) // see [RULE5]
        (tx_start_s ##0 g_dir[DIR_TX].mode_reg) |->
        ##1 transmit_end_marker_n [*8] ##4
        ($fell(transmit_frame_sync_n) && !transmit_end_marker_n))
        else $error("byte end marker wrong");
    byte_cycle_a: assert property (@(posedge shift_clk) disable iff (!link_rst_n) // see [RULE6]
        ($fell(receive_frame_sync_n) && !receive_end_marker_n) |->
        !receive_end_marker_n [*8] ##5 $rose(receive_end_marker_n))
        else $error("byte cycle length wrong");
    gain_decode_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE7]
        ##1 feedback_ratio == (($past(gain_select_low_bit) == $past(gain_select_high_bit))
            ? RATIO_X1 : ($past(gain_select_low_bit) ? RATIO_X2 : RATIO_X4)))
        else $error("gain ratio decode wrong");
    sync_pulse_a: assert property (@(posedge shift_clk) disable iff (!link_rst_n) // see [RULE8]
        $fell(transmit_frame_sync_n) |=> transmit_frame_sync_n)
        else $error("frame sync longer than one clock");
    first_bit_a: assert property (@(posedge shift_clk) disable iff (!link_rst_n) // see [RULE8]
        rx_start_s |=> (receive_data_out == $past(rx_shift_reg[SAMPLE_W-1])))
        else $error("first data bit not after frame sync");
    adc_accept_a: assert property (@(posedge clk) disable iff (!reset_n)
        (adc_valid && adc_ready) |=> !adc_ready)
        else $error("sample accept did not drop ready");
endmodule

// ==== sim/csft_host_model.sv ====
// host serial port model that trades words with the codec link
`timescale 1ns/1ps
module csft_host_model (
    input  wire logic        shift_clk, // link shift clock
    input  wire logic        byte_mode, // 1 byte, 0 word
    input  wire logic [15:0] tx_word,   // word to send
    input  wire logic        rx_fs_n,   // receive frame sync
    input  wire logic        tx_fs_n,   // transmit frame sync
    input  wire logic        rx_end_n,  // receive end marker
    input  wire logic        tx_end_n,  // transmit end marker
    input  wire logic        rx_bit,    // serial data from codec
    output logic             tx_bit,    // serial data to codec
    output logic [15:0]      rx_word,   // last word assembled
    output int               rx_cnt     // words assembled
);
    logic [4:0]  rx_left = 5'h0;
    logic [4:0]  tx_left = 5'h0;
    logic [15:0] rx_sh   = 16'h0000;
    logic [15:0] tx_sh   = 16'h0000;
    logic        rx_low  = 1'b0;
    initial begin
        tx_bit  = 1'b0;
        rx_word = 16'h0000;
        rx_cnt  = 0;
    end
    always @(posedge shift_clk) begin
        if (!rx_fs_n) begin
            rx_left <= byte_mode ? 5'h8 : 5'h10;
            rx_low  <= byte_mode && !rx_end_n;
        end else if (rx_left != 5'h0) begin
            rx_sh   <= {rx_sh[14:0], rx_bit};
            rx_left <= rx_left - 5'h1;
            if (rx_left == 5'h1 && (!byte_mode || rx_low)) begin
                rx_word <= {rx_sh[14:0], rx_bit};
                rx_cnt  <= rx_cnt + 1;
            end
        end
    end
    // first bit leaves on the edge that sees the sync; setup slots toggle
    always @(posedge shift_clk) begin
        if (!tx_fs_n) begin
            tx_bit  <= (byte_mode && !tx_end_n) ? tx_word[7] : tx_word[15];
            tx_sh   <= (byte_mode && !tx_end_n) ? {tx_word[6:0], 9'h000} : {tx_word[14:0], 1'b0};
            tx_left <= byte_mode ? 5'h7 : 5'hf;
        end else if (tx_left != 5'h0) begin
            tx_bit  <= tx_sh[15];
            tx_sh   <= {tx_sh[14:0], 1'b0};
            tx_left <= tx_left - 5'h1;
        end else begin
            tx_bit <= ~tx_bit;
        end
    end
endmodule

// ==== sim/test_codec_serial_frame_timing.sv ====
// self-checking bench for the codec serial frame timing block
`timescale 1ns/1ps
module test_codec_serial_frame_timing;
    import csft_pkg::*;
    localparam int ADC_P = 30;
    localparam int DAC_P = 36;
    logic        clk = 1'b0, sclk = 1'b0, reset_n = 1'b0, byte_mode = 1'b0;
    logic        g_lo = 1'b0, g_hi = 1'b0, adc_valid = 1'b0;
    logic [15:0] adc_word = 16'h0000, host_word = 16'ha5c3;
    logic [2:0]  ratio;
    logic        adc_ready, dac_valid, tx_bit, rx_bit, rx_fs_n, tx_fs_n, rx_end_n, tx_end_n;
    logic [15:0] dac_word, rx_word;
    int          rx_cnt, error_cnt = 0, checks_done = 0, cyc = 0, sc = 0;
    int          rx_t = 0, tx_t = 0, rx_gap = 0, tx_gap = 0, byte_gap = 0, end_dly = 0;
    logic        rxs_q = 1'b1, txs_q = 1'b1, rxe_q = 1'b1;
    always #50 clk = ~clk;
    initial begin
        #7;
        forever #16 sclk = ~sclk;
    end
    csft_frame_timing #(.ADC_PERIOD(ADC_P), .DAC_PERIOD(DAC_P)) csft_frame_timing_inst (
        .clk(clk), .reset_n(reset_n), .shift_clk(sclk), .byte_mode(byte_mode),
        .gain_select_low_bit(g_lo), .gain_select_high_bit(g_hi), .feedback_ratio(ratio),
        .adc_word(adc_word), .adc_valid(adc_valid), .adc_ready(adc_ready),
        .dac_word(dac_word), .dac_valid(dac_valid), .transmit_data_in(tx_bit),
        .receive_data_out(rx_bit), .receive_frame_sync_n(rx_fs_n),
        .transmit_frame_sync_n(tx_fs_n), .receive_end_marker_n(rx_end_n),
        .transmit_end_marker_n(tx_end_n));
    csft_host_model csft_host_model_inst (
        .shift_clk(sclk), .byte_mode(byte_mode), .tx_word(host_word), .rx_fs_n(rx_fs_n),
        .tx_fs_n(tx_fs_n), .rx_end_n(rx_end_n), .tx_end_n(tx_end_n), .rx_bit(rx_bit),
        .tx_bit(tx_bit), .rx_word(rx_word), .rx_cnt(rx_cnt));
    // stamps of sync and end marker falls, in shift clocks
    always @(posedge sclk) begin
        sc    <= sc + 1;
        rxs_q <= rx_fs_n;
        txs_q <= tx_fs_n;
        rxe_q <= rx_end_n;
        if (!rx_fs_n && rxs_q) begin
            rx_t <= sc;
            if (rx_end_n) rx_gap <= sc - rx_t;
            else byte_gap <= sc - rx_t;
        end
        if (!tx_fs_n && txs_q) tx_t <= sc;
        if (!tx_fs_n && txs_q && tx_end_n) tx_gap <= sc - tx_t;
        if (!rx_end_n && rxe_q) end_dly <= sc - rx_t;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wait_words(input int n);
        int c0;
        c0 = rx_cnt;
        for (int k = 0; k < 4000 && rx_cnt < c0 + n; k++) @(negedge clk);
    endtask
    task automatic offer(input logic [15:0] w);
        @(negedge clk);
        adc_word  = w;
        adc_valid = 1'b1;
        for (int k = 0; k < 100 && adc_ready !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        adc_valid = 1'b0;
    endtask
    task automatic get_dac(input logic [15:0] exp);
        for (int k = 0; k < 2000 && dac_valid !== 1'b1; k++) @(negedge clk);
        check(dac_word, exp);
        @(negedge clk);
    endtask
    task automatic test_gain;
        logic [2:0] exp [4];
        exp = '{RATIO_X1, RATIO_X2, RATIO_X4, RATIO_X1};
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            {g_hi, g_lo} = 2'(i);
            repeat (2) @(negedge clk);
            check(16'(ratio), 16'(exp[i]));
        end
        $display("gain decode test done");
    endtask
    task automatic test_word(input logic [15:0] w);
        @(negedge clk);
        byte_mode = 1'b0;
        offer(w);
        // enough words that both engines have run two word-mode frames after a mode change
        wait_words(4);
        check(rx_word, w);
        check(16'(rx_gap), 16'(ADC_P));
        check(16'(tx_gap), 16'(DAC_P));
        check(16'(end_dly), 16'h0011);
        get_dac(host_word);
        $display("word format test done");
    endtask
    task automatic test_byte;
        @(negedge clk);
        byte_mode = 1'b1;
        host_word = 16'h3c96;
        offer(16'hbe01);
        wait_words(4);
        check(rx_word, 16'hbe01);
        check(16'(byte_gap), 16'h000c);
        get_dac(16'h3c96);
        $display("byte mode test done");
    endtask
    initial begin
        repeat (2) @(negedge clk);
        check(16'(ratio), 16'(RATIO_X1));
        check(16'(adc_ready), 16'h0001);
        check(16'({rx_fs_n, tx_fs_n, rx_end_n, tx_end_n}), 16'h000f);
        reset_n = 1'b1;
        test_gain;
        test_word(16'h1234);
        test_byte;
        test_word(16'h8001);
        tally_and_finish;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
endmodule
